// ===== cdlm_defines.svh
// Register offsets, field positions, reset values and timing counts of the deskew lock monitor
`ifndef CDLM_DEFINES_SVH
`define CDLM_DEFINES_SVH

// Byte offsets of the register words
`define CDLM_OFS_CTRL 4'h0
`define CDLM_OFS_STATUS 4'h4
`define CDLM_OFS_TAP 4'h8
`define CDLM_OFS_PERIOD 4'hc

// Control word fields
`define CDLM_CTRL_SOFT_RST 0
`define CDLM_CTRL_SRC_SYNC 1
`define CDLM_CTRL_SYN_EN 2
`define CDLM_CTRL_STARTUP_WAIT 3
`define CDLM_CTRL_W 4
// Control reset value: system-synchronous, synthesized output off, startup does not wait
`define CDLM_CTRL_RESET 4'h0

// Status word fields
`define CDLM_STAT_LOCKED 0
`define CDLM_STAT_IN_STOP 1
`define CDLM_STAT_SYN_STOP 2

// Timing: system clock rate and the synthesized-stop delay
`define CDLM_CLK_MHZ 25
`define CDLM_SYNTH_STOP_US 100
`define CDLM_SYNTH_STOP_CYC (`CDLM_SYNTH_STOP_US * `CDLM_CLK_MHZ)

`endif

// ===== cdlm_pkg.sv
// Types shared by the deskew lock monitor
package cdlm_pkg;

   // Lock controller states, one-hot
   typedef enum logic [3:0]
   {
      CDLM_SEEK = 4'h1,
      CDLM_VERIFY = 4'h2,
      CDLM_LOCKED = 4'h4,
      CDLM_LOST = 4'h8
   } cdlm_lock_state_t;

endpackage : cdlm_pkg

// ===== cdlm_delay_line.sv
// Tapped delay line that holds sampled reference clock levels
`timescale 1ns/1ps
module cdlm_delay_line #(
   parameter int DEPTH = 64,
   parameter int TAP_W = 6
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic din_i,
   input wire logic [TAP_W-1:0] tap_i,
   output logic dout_o
);

   // Refuse shapes the tap selector cannot address
   if (DEPTH < 2 || (1 << TAP_W) < DEPTH)
   begin : g_bad_shape
      $error("cdlm_delay_line: DEPTH and TAP_W do not fit");
   end

   // One stage per system clock, the delay element step
   logic [DEPTH-1:0] line_q;

   // Shift the sampled level along the line
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         line_q <= '0;
      end
      else
      begin
         line_q <= {line_q[DEPTH-2:0], din_i};
      end
   end

   // Selected tap, registered so the output clock comes from a flop
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         dout_o <= 1'b0;
      end
      else
      begin
         dout_o <= line_q[tap_i];
      end
   end

endmodule : cdlm_delay_line

// ===== cdlm_lock_monitor.sv
// Deskew unit: delay-line lock loop, stop detection, startup hold and register slave
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cdlm_defines.svh"
module cdlm_lock_monitor #(
   parameter int TAPS = 64,
   parameter int FB_SYS_TAPS = 4,
   parameter int LOCK_HOLD = 8,
   parameter int JIT_TOL = 2,
   parameter int UPD_DIV = 4,
   parameter int SYN_DIV = 2
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic reference_clock_in_i,
   input wire logic feedback_clock_in_i,
   input wire logic cfg_active_i,
   input wire logic lock_wait_startup_cycle_i,
   output logic zero_phase_output_o,
   output logic synthesized_output_o,
   output logic synthesized_output_inverted_o,
   output logic locked_o,
   output logic startup_hold_o,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);

   localparam int TAP_W = $clog2(TAPS);
   localparam int CNT_W = 16;

   // Refuse parameter values the logic cannot serve
   if (TAPS < 2 || FB_SYS_TAPS < 2 || LOCK_HOLD < 2 || LOCK_HOLD > 255 || UPD_DIV < 1 || UPD_DIV > 255
       || SYN_DIV < 1 || SYN_DIV > 255 || JIT_TOL < 0)
   begin : g_bad_param
      $error("cdlm_lock_monitor: parameter out of range");
   end

   // Absolute difference of two period counts
   function automatic logic [CNT_W-1:0] cdlm_absdiff(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
      cdlm_absdiff = (a > b) ? (a - b) : (b - a);
   endfunction : cdlm_absdiff

   // Pin synchronisers, two flops each
   logic ref_s1_q, ref_s2_q, fb_s1_q, fb_s2_q;
   // Previous levels for edge detection
   logic ref_p_q, fb_p_q, out_p_q;
   // Feedback delay element pipeline
   logic [FB_SYS_TAPS-1:0] fb_pipe_q;
   // Control word and Avalon handshake
   logic [`CDLM_CTRL_W-1:0] ctrl_q;
   logic ack_q;
   // Lock loop state
   cdlm_pkg::cdlm_lock_state_t state_q;
   logic [TAP_W-1:0] tap_q;
   logic [7:0] match_cnt_q;
   logic [7:0] upd_cnt_q;
   logic [CNT_W-1:0] since_ref_q, period_q, out_since_q;
   logic ref_paused_q, in_stop_q;
   // Synthesized output
   logic [7:0] syn_cnt_q;
   logic synth_q, synth_n_q, synth_halt_q, synth_stop_q;
   logic [11:0] halt_cnt_q;
   // Combinational helpers
   logic unit_rst, fb_used, ref_rise, fb_rise, line_out, out_edge, upd_en, wr_fire, locked;
   logic [CNT_W-1:0] meas;

   // Unit reset: configuration in progress or software request
   assign unit_rst = cfg_active_i | ctrl_q[`CDLM_CTRL_SOFT_RST];
   assign locked = (state_q == cdlm_pkg::CDLM_LOCKED);

   // Two-flop synchronisers for both clock pins
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         fb_s1_q <= 1'b0;
         fb_s2_q <= 1'b0;
      end
      else
      begin
         ref_s1_q <= reference_clock_in_i;
         ref_s2_q <= ref_s1_q;
         fb_s1_q <= feedback_clock_in_i;
         fb_s2_q <= fb_s1_q;
      end
   end

   // Feedback delay element: fixed taps unless source-synchronous
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         fb_pipe_q <= '0;
      end
      else
      begin
         fb_pipe_q <= {fb_pipe_q[FB_SYS_TAPS-2:0], fb_s2_q};
      end
   end
   assign fb_used = ctrl_q[`CDLM_CTRL_SRC_SYNC] ? fb_s2_q : fb_pipe_q[FB_SYS_TAPS-1];

   // Edge history for the phase detector and output monitor
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ref_p_q <= 1'b0;
         fb_p_q <= 1'b0;
         out_p_q <= 1'b0;
      end
      else
      begin
         ref_p_q <= ref_s2_q;
         fb_p_q <= fb_used;
         out_p_q <= line_out;
      end
   end
   assign ref_rise = ref_s2_q & ~ref_p_q;
   assign fb_rise = fb_used & ~fb_p_q;
   assign out_edge = line_out ^ out_p_q;
   // Period just completed, counted in system clocks
   assign meas = since_ref_q + 1'b1;

   // Delay line: output is the reference delayed by the selected tap
   cdlm_delay_line #(
      .DEPTH(TAPS),
      .TAP_W(TAP_W)
   ) u_line (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .din_i(ref_s2_q),
      .tap_i(tap_q),
      .dout_o(line_out)
   );
   assign zero_phase_output_o = line_out;

   // Tap update rate divider, one-cycle enable
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         upd_cnt_q <= 8'h00;
      end
      else if (upd_cnt_q == 8'(UPD_DIV - 1))
      begin
         upd_cnt_q <= 8'h00;
      end
      else
      begin
         upd_cnt_q <= upd_cnt_q + 8'h01;
      end
   end
   assign upd_en = (upd_cnt_q == 8'(UPD_DIV - 1));

   // Cycles since the last reference edge, saturating
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         since_ref_q <= '0;
      end
      else if (ref_rise)
      begin
         since_ref_q <= '0;
      end
      else if (since_ref_q != '1)
      begin
         since_ref_q <= since_ref_q + 1'b1;
      end
   end

   // Reference pause: no edge for two periods; any restart phase is fine
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ref_paused_q <= 1'b0;
      end
      else if (unit_rst || ref_rise)
      begin
         ref_paused_q <= 1'b0;
      end
      else if (period_q != '0 && since_ref_q > {period_q[CNT_W-2:0], 1'b0})
      begin
         ref_paused_q <= 1'b1;
      end
   end

   // Lock controller: seek taps, verify coincidence, hold or lose lock
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_q <= cdlm_pkg::CDLM_SEEK;
         tap_q <= '0;
         match_cnt_q <= 8'h00;
         period_q <= '0;
      end
      else if (unit_rst)
      begin
         state_q <= cdlm_pkg::CDLM_SEEK;
         tap_q <= '0;
         match_cnt_q <= 8'h00;
         period_q <= '0;
      end
      else
      begin
         unique case (state_q)
            cdlm_pkg::CDLM_SEEK:
            begin
               // Coincident edges mean feedback sits one full period behind
               if (ref_rise && fb_rise)
               begin
                  state_q <= cdlm_pkg::CDLM_VERIFY;
                  match_cnt_q <= 8'h01;
               end
               else if (ref_rise && upd_en)
               begin
                  tap_q <= (tap_q == TAP_W'(TAPS - 1)) ? '0 : tap_q + 1'b1;
               end
            end
            cdlm_pkg::CDLM_VERIFY:
            begin
               // Demand a run of coincident edges before declaring lock
               if (ref_rise && fb_rise)
               begin
                  match_cnt_q <= match_cnt_q + 8'h01;
                  period_q <= meas;
                  if (match_cnt_q == 8'(LOCK_HOLD - 1))
                  begin
                     state_q <= cdlm_pkg::CDLM_LOCKED;
                  end
               end
               else if (ref_rise)
               begin
                  state_q <= cdlm_pkg::CDLM_SEEK;
                  match_cnt_q <= 8'h00;
               end
            end
            cdlm_pkg::CDLM_LOCKED:
            begin
               // Period check skips the first edge after a pause
               if (ref_rise && !ref_paused_q && cdlm_absdiff(meas, period_q) > CNT_W'(JIT_TOL))
               begin
                  state_q <= cdlm_pkg::CDLM_LOST;
               end
            end
            cdlm_pkg::CDLM_LOST:
            begin
               state_q <= cdlm_pkg::CDLM_LOST;
            end
            default:
            begin
               state_q <= cdlm_pkg::CDLM_SEEK;
            end
         endcase
      end
   end
   assign locked_o = locked;

   // Cycles since the last output edge
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         out_since_q <= '0;
      end
      else if (out_edge)
      begin
         out_since_q <= '0;
      end
      else if (out_since_q != '1)
      begin
         out_since_q <= out_since_q + 1'b1;
      end
   end

   // Input-stop flag: set once drained output goes quiet, cleared on refill
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         in_stop_q <= 1'b0;
      end
      else if (!locked || unit_rst)
      begin
         in_stop_q <= 1'b0;
      end
      else if (out_edge)
      begin
         in_stop_q <= 1'b0;
      end
      else if (ref_paused_q && out_since_q > period_q)
      begin
         in_stop_q <= 1'b1;
      end
   end

   // Synthesized output divider, runs only while locked and not halted
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         syn_cnt_q <= 8'h00;
         synth_q <= 1'b0;
         synth_n_q <= 1'b1;
      end
      else if (unit_rst || !ctrl_q[`CDLM_CTRL_SYN_EN])
      begin
         syn_cnt_q <= 8'h00;
         synth_q <= 1'b0;
         synth_n_q <= 1'b1;
      end
      else if (locked && !synth_halt_q)
      begin
         if (syn_cnt_q == 8'(SYN_DIV - 1))
         begin
            syn_cnt_q <= 8'h00;
            synth_q <= ~synth_q;
            synth_n_q <= synth_q;
         end
         else
         begin
            syn_cnt_q <= syn_cnt_q + 8'h01;
         end
      end
   end
   assign synthesized_output_o = synth_q;
   assign synthesized_output_inverted_o = synth_n_q;

   // Halt and stopped flag: only a unit reset recovers them
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         synth_halt_q <= 1'b0;
         synth_stop_q <= 1'b0;
         halt_cnt_q <= 12'h000;
      end
      else if (unit_rst)
      begin
         synth_halt_q <= 1'b0;
         synth_stop_q <= 1'b0;
         halt_cnt_q <= 12'h000;
      end
      else if (!synth_halt_q)
      begin
         synth_halt_q <= ctrl_q[`CDLM_CTRL_SYN_EN] & ref_paused_q;
      end
      else if (halt_cnt_q == 12'(`CDLM_SYNTH_STOP_CYC - 1))
      begin
         synth_stop_q <= 1'b1;
      end
      else
      begin
         halt_cnt_q <= halt_cnt_q + 12'h001;
      end
   end

   // Startup held only when the wait option is set and not yet locked
   assign startup_hold_o = ctrl_q[`CDLM_CTRL_STARTUP_WAIT] & lock_wait_startup_cycle_i & ~locked;

   // Avalon slave: one wait cycle, then the access completes
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign wr_fire = avs_write_i & ack_q;
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      end
   end

   // Control word; soft reset clears itself the next cycle
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q <= `CDLM_CTRL_RESET;
      end
      else if (wr_fire && avs_address_i == `CDLM_OFS_CTRL && avs_byteenable_i[0])
      begin
         ctrl_q <= avs_writedata_i[`CDLM_CTRL_W-1:0];
      end
      else
      begin
         ctrl_q[`CDLM_CTRL_SOFT_RST] <= 1'b0;
      end
   end

   // Read data captured in the wait cycle, stands at the completing edge
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         avs_readdata_o <= 32'h0000_0000;
      end
      else if (avs_read_i && !ack_q)
      begin
         unique case (avs_address_i)
            `CDLM_OFS_CTRL: avs_readdata_o <= {28'h0000000, ctrl_q};
            `CDLM_OFS_STATUS: avs_readdata_o <= {29'h0, synth_stop_q, in_stop_q, locked};
            `CDLM_OFS_TAP: avs_readdata_o <= 32'(tap_q);
            `CDLM_OFS_PERIOD: avs_readdata_o <= {16'h0000, period_q};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   chk_instop_needs_lock: assert property (!locked |=> !in_stop_q)
      else $error("input-stop flag high while unlocked");
   chk_lost_is_sticky: assert property (state_q == cdlm_pkg::CDLM_LOST && !unit_rst |=> !locked_o)
      else $error("lock returned without unit reset");
   chk_synth_stop_delay: assert property ($rose(synth_halt_q) |-> !synth_stop_q [*8])
      else $error("synthesized-stop flag set too early");
   chk_synth_stop_at_count: assert property (synth_halt_q && !unit_rst
      && halt_cnt_q == 12'(`CDLM_SYNTH_STOP_CYC - 1) |=> synth_stop_q)
      else $error("synthesized-stop flag not set at count");
   chk_synth_held: assert property (synth_halt_q && !unit_rst |=> $stable(synth_q) && synth_halt_q)
      else $error("synthesized output moved while halted");
   chk_lock_after_run: assert property ($rose(locked) |-> $past(match_cnt_q) == 8'(LOCK_HOLD - 1))
      else $error("lock without full coincidence run");
   chk_tap_steps: assert property (state_q == cdlm_pkg::CDLM_SEEK && ref_rise && !fb_rise && upd_en
      && !unit_rst |=> tap_q != $past(tap_q))
      else $error("tap not stepped on missed edge");
   chk_config_reset: assert property (cfg_active_i |=> state_q == cdlm_pkg::CDLM_SEEK && !locked_o)
      else $error("unit not held in reset during configuration");
   chk_pause_keeps_lock: assert property (locked && ref_paused_q && !unit_rst |=> locked)
      else $error("lock dropped during reference pause");
   chk_startup_hold: assert property (!ctrl_q[`CDLM_CTRL_STARTUP_WAIT] |-> !startup_hold_o)
      else $error("startup held without wait option");

endmodule : cdlm_lock_monitor

// ===== cdlm_clk_partner.sv
// Board reference clock source and clock distribution feedback model
`timescale 1ns/1ps
module cdlm_clk_partner #(
   parameter int DIST = 3
) (
   input wire logic clk_sys_i,
   input wire logic run_i,
   input wire logic [7:0] half_i,
   input wire logic zero_phase_output_i,
   output logic reference_clock_in_o,
   output logic feedback_clock_in_o
);
   logic [7:0] cnt_q = 8'h00; // Cycles spent in the current phase
   logic ref_q = 1'b0; // Reference level
   logic [DIST-1:0] dist_q = '0; // Distribution network delay stages

   // Reference source: a stop freezes it inside a steady phase, restart keeps the period
   always_ff @(posedge clk_sys_i)
   begin
      if (!run_i)
      begin
         cnt_q <= cnt_q;
      end
      else if (cnt_q >= half_i - 8'h01)
      begin
         cnt_q <= 8'h00;
         ref_q <= ~ref_q;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Feedback returns the zero-phase output after the distribution delay
   always_ff @(posedge clk_sys_i)
   begin
      dist_q <= {dist_q[DIST-2:0], zero_phase_output_i};
   end

   assign reference_clock_in_o = ref_q;
   assign feedback_clock_in_o = dist_q[DIST-1];
endmodule : cdlm_clk_partner

// ===== clock_deskew_lock_monitor_tb.sv
// Self-checking bench for the deskew lock monitor
`timescale 1ns/1ps
module clock_deskew_lock_monitor_tb;
   logic clk_sys_i = 1'b0; // System clock
   logic resetn_i = 1'b0; // Reset, active low
   logic cfg_active_i = 1'b1; // Configuration in progress
   logic lock_wait_startup_cycle_i = 1'b0; // Sequencer in lock-wait cycle
   logic run = 1'b0; // Reference clock running
   logic [7:0] half = 8'h08; // Reference half period in cycles
   logic ref_clk, fb_clk, zero_out, syn_out, syn_inv, locked, hold;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   int err_total = 0; // Mismatches
   int n_tests = 0; // Comparisons
   int cyc = 0; // Cycle count for the hang guard
   logic [31:0] rd, tap_sys, tap_src; // Read results
   logic s0, s1; // Sampled synthesized and zero-phase outputs

   // Clock generator, 40 ns period
   always #20 clk_sys_i = ~clk_sys_i;

   cdlm_lock_monitor #(.UPD_DIV(1), .LOCK_HOLD(2)) i_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .reference_clock_in_i(ref_clk), .feedback_clock_in_i(fb_clk),
      .cfg_active_i(cfg_active_i), .lock_wait_startup_cycle_i(lock_wait_startup_cycle_i),
      .zero_phase_output_o(zero_out), .synthesized_output_o(syn_out),
      .synthesized_output_inverted_o(syn_inv), .locked_o(locked), .startup_hold_o(hold),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

   cdlm_clk_partner #(.DIST(3)) i_partner (
      .clk_sys_i(clk_sys_i), .run_i(run), .half_i(half), .zero_phase_output_i(zero_out),
      .reference_clock_in_o(ref_clk), .feedback_clock_in_o(fb_clk));

   // Compares one value and counts it
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Prints the counts and the verdict, then stops
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // Avalon-MM access: hold until waitrequest is seen low at a rising edge
   // Leading edge keeps two calls from touching the strobes in one time step
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus

   // Reads a word and compares it
   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask : rd_chk

   // Waits a bounded time for lock and checks it
   task wait_lock;
      int i;
      for (i = 0; i < 3000 && locked !== 1'b1; i++)
         @(posedge clk_sys_i);
      chk(locked, 1'b1);
   endtask : wait_lock

   // Hang guard
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         summarize();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      chk(locked, 1'b0);
      chk(syn_inv, 1'b1);
      chk(hold, 1'b0);
      rd_chk(4'h0, 32'h0);
      rd_chk(4'h2, 32'h0);
      bus(1'b1, 4'h4, 32'h7, rd);
      rd_chk(4'h4, 32'h0);
      // Control write with lane 0 disabled must be ignored
      avs_byteenable_i <= 4'he;
      bus(1'b1, 4'h0, 32'h4, rd);
      avs_byteenable_i <= 4'hf;
      rd_chk(4'h0, 32'h0);
      $display("test reset done");
      // Clock runs but configuration holds the unit
      run <= 1'b1;
      repeat (400) @(posedge clk_sys_i);
      chk(locked, 1'b0);
      cfg_active_i <= 1'b0;
      bus(1'b1, 4'h0, 32'hc, rd);
      rd_chk(4'h0, 32'hc);
      chk(hold, 1'b0);
      // Sequencer reaches the lock-wait cycle only after the I/O release cycle
      lock_wait_startup_cycle_i <= 1'b1;
      @(posedge clk_sys_i);
      chk(hold, 1'b1);
      wait_lock();
      @(negedge clk_sys_i);
      chk(hold, 1'b0);
      rd_chk(4'h4, 32'h1);
      rd_chk(4'hc, 32'h10);
      bus(1'b0, 4'h8, 32'h0, tap_sys);
      @(negedge clk_sys_i);
      s0 = syn_out;
      repeat (2) @(negedge clk_sys_i);
      chk(syn_out, !s0);
      chk(syn_inv, s0);
      $display("test lock done");
      // Reference pause with the synthesized output in use
      @(posedge clk_sys_i);
      run <= 1'b0;
      repeat (300) @(posedge clk_sys_i);
      rd_chk(4'h4, 32'h3);
      s1 = zero_out;
      repeat (2000) @(posedge clk_sys_i);
      chk(zero_out, s1);
      rd_chk(4'h4, 32'h3);
      repeat (500) @(posedge clk_sys_i);
      rd_chk(4'h4, 32'h7);
      s0 = syn_out;
      run <= 1'b1;
      repeat (100) @(posedge clk_sys_i);
      rd_chk(4'h4, 32'h5);
      chk(syn_out, s0);
      chk(syn_inv, !s0);
      $display("test pause done");
      // Source-synchronous relock after a soft reset
      bus(1'b1, 4'h0, 32'h3, rd);
      rd_chk(4'h4, 32'h0);
      wait_lock();
      bus(1'b0, 4'h8, 32'h0, tap_src);
      chk(tap_src - tap_sys, 32'h4);
      $display("test deskew adjust done");
      // Period change beyond tolerance
      half <= 8'h0c;
      repeat (300) @(posedge clk_sys_i);
      chk(locked, 1'b0);
      rd_chk(4'h4, 32'h0);
      half <= 8'h08;
      repeat (300) @(posedge clk_sys_i);
      chk(locked, 1'b0);
      bus(1'b1, 4'h0, 32'h3, rd);
      wait_lock();
      $display("test period change done");
      // Configuration again resets the unit
      cfg_active_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      chk(locked, 1'b0);
      cfg_active_i <= 1'b0;
      wait_lock();
      $display("test configuration done");
      summarize();
   end
endmodule : clock_deskew_lock_monitor_tb
